/* verilog/mpfc_cfg.svh */
// constants of the pause flow-control block
`ifndef MPFC_CFG_SVH
`define MPFC_CFG_SVH
// ===================================================
// register offsets (byte addresses)
`define MPFC_OFS_NET_CTRL   8'h00
`define MPFC_OFS_NET_CFG    8'h04
`define MPFC_OFS_INT_STAT   8'h08
`define MPFC_OFS_INT_MASK   8'h0c
`define MPFC_OFS_PAUSE_TIME 8'h10
`define MPFC_OFS_TX_QUANT   8'h14
`define MPFC_OFS_SA1_BOT    8'h18
`define MPFC_OFS_SA1_TOP    8'h1c
`define MPFC_OFS_RX_STAT    8'h20
// ===================================================
// field positions
`define MPFC_CTRL_TX_EN     3
`define MPFC_CTRL_PAUSE_A   11
`define MPFC_CTRL_PAUSE_B   12
`define MPFC_CFG_FULL_DUP   1
`define MPFC_CFG_RETRY      12
`define MPFC_CFG_PAUSE_EN   13
`define MPFC_CFG_PFC_NEG    16
`define MPFC_INT_PAUSE_NZ   12
`define MPFC_INT_PAUSE_Z    13
// ===================================================
// reset values
`define MPFC_RST_CTRL       32'h0000_0000
`define MPFC_RST_CFG        32'h0000_0000
`define MPFC_RST_MASK       32'h0000_0000
`define MPFC_RST_QUANT      16'hffff
// ===================================================
// frame constants and timing counts
`define MPFC_DA_CTRL        48'h0180_c200_0001
`define MPFC_TYPE_CTRL      16'h8808
`define MPFC_OPC_PAUSE      16'h0001
`define MPFC_MIN_FRAME      6'd60
`define MPFC_SLOT_BITS      512
`define MPFC_CRC_INIT       32'hffff_ffff
`define MPFC_CRC_POLY       32'hedb8_8320
`endif

/* verilog/mpfc_pkg.sv */
// types of the pause flow-control block
package mpfc_pkg;
  // gray-coded transmit sequencer states
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_BODY = 2'b01,
    TX_FCS  = 2'b11
  } mpfc_tx_e;
  typedef logic [15:0] mpfc_quant_t;
endpackage

/* verilog/mpfc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module mpfc_sync
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // mpfc_sync

/* verilog/mpfc_crc32.sv */
// one-byte step of the ethernet frame check sequence
`timescale 1ns/100ps
`include "mpfc_cfg.svh"
module mpfc_crc32
(
  // running value and byte
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  byte_in,
  output logic      [31:0] crc_out
);
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    // reflected form: bits leave lsb first on the wire
    for (int i = 0; i < 8; i++)
    begin
      if (c[0] ^ byte_in[i])
        c = (c >> 1) ^ `MPFC_CRC_POLY;
      else
        c = c >> 1;
    end
    crc_out = c;
  end
endmodule // mpfc_crc32

/* verilog/mpfc_top.sv */
// pause-frame flow control of an ethernet mac
// ===================================================
// What this block does
// - config bit 13 enables reaction to pause
// - each valid pause reloads the counter
// - nonzero sets status 12, zero sets 13
// - finish current frame, then hold new starts
// - half duplex: interrupt only, no pause
// - destination must be sa1 or control multicast
// - type 8808 and opcode 0001 required
// - errored frames discarded without effect
// - discard pause once pfc negotiated
// - valid pause increments receive statistic
// - count down every 512 bit times
// - retry test: count down each tx clock
// - reaching zero sets status bit 13
// - ctrl bit 11/12 requests pause transmit
// - pause frame goes between queued frames
// - sent to control multicast from sa1
// - zero pad to minimum, valid fcs
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "mpfc_cfg.svh"
module mpfc_top
#(
  parameter int BITS_PER_TICK = 8
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  // link clock from the phy side
  input  wire logic        mac_transmit_clock,
  // received byte stream from the mac
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_err,
  // mac transmit datapath
  input  wire logic        mac_tx_busy,
  output logic             tx_start_ok,
  // pause frame byte stream
  output logic             ptx_valid,
  output logic             ptx_sof,
  output logic             ptx_eof,
  output logic      [7:0]  ptx_data
);
  localparam int SLOT_TICKS = `MPFC_SLOT_BITS / BITS_PER_TICK;

  // ===================================================
  // link clock edge detection
  logic tck_s;
  logic tck_prev_q;
  logic tick;
  mpfc_sync u_tck_sync
  (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (mac_transmit_clock),
    .sync_out (tck_s)
  );
  always_ff @(posedge mclk)
  begin
    if (rst)
      tck_prev_q <= 1'b0;
    else
      tck_prev_q <= tck_s;
  end
  assign tick = tck_s & ~tck_prev_q;

  // ===================================================
  // software registers
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic [31:0] mask_q;
  logic [31:0] stat_q;
  logic [15:0] quant_q;
  logic [31:0] sa1_bot_q;
  logic [15:0] sa1_top_q;
  logic [31:0] rx_cnt_q;
  logic [15:0] pause_q;
  logic        full_dup;
  logic        tx_en;
  logic        pause_req_wr;
  logic        rx_good;
  logic        rx_nonzero;
  logic        zero_evt;
  logic [47:0] sa1;
  assign full_dup = cfg_q[`MPFC_CFG_FULL_DUP];
  assign tx_en    = ctrl_q[`MPFC_CTRL_TX_EN];
  assign sa1      = {sa1_top_q, sa1_bot_q};

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_q    <= `MPFC_RST_CTRL;
      cfg_q     <= `MPFC_RST_CFG;
      mask_q    <= `MPFC_RST_MASK;
      quant_q   <= `MPFC_RST_QUANT;
      sa1_bot_q <= 32'h0000_0000;
      sa1_top_q <= 16'h0000;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        // pause request bits are strobes, not stored
        `MPFC_OFS_NET_CTRL: ctrl_q    <= reg_wdata & 32'hffff_e7ff;
        `MPFC_OFS_NET_CFG:  cfg_q     <= reg_wdata;
        `MPFC_OFS_INT_MASK: mask_q    <= reg_wdata;
        `MPFC_OFS_TX_QUANT: quant_q   <= reg_wdata[15:0];
        `MPFC_OFS_SA1_BOT:  sa1_bot_q <= reg_wdata;
        `MPFC_OFS_SA1_TOP:  sa1_top_q <= reg_wdata[15:0];
        default:            ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // write-one request gated by duplex and tx enable
  assign pause_req_wr = reg_wr && (reg_addr == `MPFC_OFS_NET_CTRL) &&
                        (reg_wdata[`MPFC_CTRL_PAUSE_A] ||
                         reg_wdata[`MPFC_CTRL_PAUSE_B]) &&
                        full_dup && tx_en;

  // status bits, set wins over clear-on-read
  logic [31:0] stat_set;
  always_comb
  begin
    stat_set = 32'h0000_0000;
    stat_set[`MPFC_INT_PAUSE_NZ] = rx_good && rx_nonzero;
    // zero quantum or countdown to zero
    stat_set[`MPFC_INT_PAUSE_Z]  = (rx_good && !rx_nonzero) || zero_evt;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      stat_q <= 32'h0000_0000;
    else if (reg_rd && reg_addr == `MPFC_OFS_INT_STAT)
      stat_q <= stat_set;
    else
      stat_q <= stat_q | stat_set;
  end
  assign irq = |(stat_q & mask_q);

  always_ff @(posedge mclk)
  begin
    if (rst)
      rx_cnt_q <= 32'h0000_0000;
    else if (rx_good)
      rx_cnt_q <= rx_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MPFC_OFS_NET_CTRL:   reg_rdata <= ctrl_q;
        `MPFC_OFS_NET_CFG:    reg_rdata <= cfg_q;
        `MPFC_OFS_INT_STAT:   reg_rdata <= stat_q;
        `MPFC_OFS_INT_MASK:   reg_rdata <= mask_q;
        `MPFC_OFS_PAUSE_TIME: reg_rdata <= {16'h0000, pause_q};
        `MPFC_OFS_TX_QUANT:   reg_rdata <= {16'h0000, quant_q};
        `MPFC_OFS_SA1_BOT:    reg_rdata <= sa1_bot_q;
        `MPFC_OFS_SA1_TOP:    reg_rdata <= {16'h0000, sa1_top_q};
        `MPFC_OFS_RX_STAT:    reg_rdata <= rx_cnt_q;
        default:              reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ===================================================
  // receive parser
  logic [4:0]  rx_idx_q;
  logic        da_mc_q;
  logic        da_sa_q;
  logic        type_q;
  logic        opc_q;
  logic        err_q;
  logic [15:0] rx_quant_q;
  logic [4:0]  idx_now;
  logic        ok_mc;
  logic        ok_sa;
  logic        ok_ty;
  logic        ok_op;
  logic        ok_er;
  logic [15:0] qn_now;
  assign idx_now = rx_sof ? 5'd0 : rx_idx_q;

  // running match flags, including the current byte
  always_comb
  begin
    logic [47:0] mc;
    logic [7:0]  sb;
    logic        first;
    first = rx_sof;
    mc    = `MPFC_DA_CTRL;
    sb    = 8'h00;
    ok_mc = first ? 1'b1 : da_mc_q;
    ok_sa = first ? 1'b1 : da_sa_q;
    ok_ty = first ? 1'b1 : type_q;
    ok_op = first ? 1'b1 : opc_q;
    ok_er = (first ? 1'b0 : err_q) | rx_err;
    qn_now = rx_quant_q;
    if (idx_now < 5'd6)
    begin
      sb = sa1[8*idx_now[2:0] +: 8];
      ok_mc = ok_mc && (rx_data == mc[8*(5-idx_now[2:0]) +: 8]);
      ok_sa = ok_sa && (rx_data == sb);
    end
    // mac control type and pause opcode
    if (idx_now == 5'd12)
      ok_ty = ok_ty && (rx_data == 8'(`MPFC_TYPE_CTRL >> 8));
    if (idx_now == 5'd13)
      ok_ty = ok_ty && (rx_data == 8'(`MPFC_TYPE_CTRL));
    if (idx_now == 5'd14)
      ok_op = ok_op && (rx_data == 8'(`MPFC_OPC_PAUSE >> 8));
    if (idx_now == 5'd15)
      ok_op = ok_op && (rx_data == 8'(`MPFC_OPC_PAUSE));
    if (idx_now == 5'd16)
      qn_now = {rx_data, 8'h00};
    if (idx_now == 5'd17)
      qn_now = {rx_quant_q[15:8], rx_data};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_idx_q   <= 5'd0;
      da_mc_q    <= 1'b0;
      da_sa_q    <= 1'b0;
      type_q     <= 1'b0;
      opc_q      <= 1'b0;
      err_q      <= 1'b0;
      rx_quant_q <= 16'h0000;
    end
    else if (rx_valid)
    begin
      rx_idx_q   <= (idx_now == 5'd31) ? idx_now : idx_now + 5'd1;
      da_mc_q    <= ok_mc;
      da_sa_q    <= ok_sa;
      type_q     <= ok_ty;
      opc_q      <= ok_op;
      err_q      <= ok_er;
      rx_quant_q <= qn_now;
    end
  end

  // errors void the frame; pfc blocks it
  assign rx_good = rx_valid && rx_eof && idx_now >= 5'd17 &&
                   (ok_mc || ok_sa) && ok_ty && ok_op && !ok_er &&
                   !cfg_q[`MPFC_CFG_PFC_NEG];
  assign rx_nonzero = qn_now != 16'h0000;

  // ===================================================
  // pause-time counter
  logic [8:0] slot_q;
  logic       stopped;
  logic       dec;
  logic       load;
  // only stopped once the current frame is done
  assign stopped = (pause_q != 16'h0000) && !mac_tx_busy;
  // load only when enabled and full duplex
  assign load = rx_good && full_dup && cfg_q[`MPFC_CFG_PAUSE_EN];
  // slot rate, or every tx clock under retry test
  assign dec = stopped && tick &&
               (cfg_q[`MPFC_CFG_RETRY] ||
                slot_q == 9'(SLOT_TICKS - 1));
  assign zero_evt = dec && !load && pause_q == 16'h0001;

  always_ff @(posedge mclk)
  begin
    if (rst || !stopped)
      slot_q <= 9'd0;
    else if (tick)
      slot_q <= (slot_q == 9'(SLOT_TICKS - 1)) ? 9'd0 : slot_q + 9'd1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      pause_q <= 16'h0000;
    else if (load)
      pause_q <= qn_now;
    else if (dec)
      pause_q <= pause_q - 16'h0001;
  end

  // ===================================================
  // pause frame transmitter
  mpfc_pkg::mpfc_tx_e st_q;
  logic        pend_q;
  logic [5:0]  tx_idx_q;
  logic [1:0]  fcs_idx_q;
  logic [31:0] crc_q;
  logic [31:0] crc_nx;
  logic [7:0]  body_byte;
  logic [31:0] fcs_word;
  mpfc_crc32 u_crc
  (
    .crc_in  (crc_q),
    .byte_in (body_byte),
    .crc_out (crc_nx)
  );
  assign fcs_word = ~crc_q;

  always_comb
  begin
    logic [47:0] da;
    da = `MPFC_DA_CTRL;
    body_byte = 8'h00;
    if (tx_idx_q < 6'd6)
      body_byte = da[8*(5-tx_idx_q[2:0]) +: 8];
    else if (tx_idx_q < 6'd12)
      // full-width index: a 3-bit difference would wrap past the word
      body_byte = sa1[8*(tx_idx_q - 6'd6) +: 8];
    else if (tx_idx_q == 6'd12)
      body_byte = 8'(`MPFC_TYPE_CTRL >> 8);
    else if (tx_idx_q == 6'd13)
      body_byte = 8'(`MPFC_TYPE_CTRL);
    else if (tx_idx_q == 6'd14)
      body_byte = 8'(`MPFC_OPC_PAUSE >> 8);
    else if (tx_idx_q == 6'd15)
      body_byte = 8'(`MPFC_OPC_PAUSE);
    else if (tx_idx_q == 6'd16)
      body_byte = quant_q[15:8];
    else if (tx_idx_q == 6'd17)
      body_byte = quant_q[7:0];
  end

  // request held until the frame actually starts
  always_ff @(posedge mclk)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (pause_req_wr)
      pend_q <= 1'b1;
    else if (st_q == mpfc_pkg::TX_IDLE && tick && !mac_tx_busy)
      pend_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q      <= mpfc_pkg::TX_IDLE;
      tx_idx_q  <= 6'd0;
      fcs_idx_q <= 2'd0;
      crc_q     <= `MPFC_CRC_INIT;
      ptx_valid <= 1'b0;
      ptx_sof   <= 1'b0;
      ptx_eof   <= 1'b0;
      ptx_data  <= 8'h00;
    end
    else if (tick)
    begin
      case (st_q)
        mpfc_pkg::TX_IDLE:
        begin
          ptx_valid <= 1'b0;
          ptx_eof   <= 1'b0;
          tx_idx_q  <= 6'd0;
          fcs_idx_q <= 2'd0;
          crc_q     <= `MPFC_CRC_INIT;
          // start at once, or in the gap after a frame
          if (pend_q && !mac_tx_busy)
            st_q <= mpfc_pkg::TX_BODY;
        end
        mpfc_pkg::TX_BODY:
        begin
          ptx_valid <= 1'b1;
          ptx_sof   <= tx_idx_q == 6'd0;
          ptx_data  <= body_byte;
          crc_q     <= crc_nx;
          tx_idx_q  <= tx_idx_q + 6'd1;
          // zero fill up to minimum length
          if (tx_idx_q == `MPFC_MIN_FRAME - 6'd1)
            st_q <= mpfc_pkg::TX_FCS;
        end
        mpfc_pkg::TX_FCS:
        begin
          ptx_sof   <= 1'b0;
          // fcs sent inverted, low byte first
          ptx_data  <= fcs_word[8*fcs_idx_q +: 8];
          ptx_eof   <= fcs_idx_q == 2'd3;
          fcs_idx_q <= fcs_idx_q + 2'd1;
          if (fcs_idx_q == 2'd3)
            st_q <= mpfc_pkg::TX_IDLE;
        end
        default: st_q <= mpfc_pkg::TX_IDLE;
      endcase
    end
  end

  // queued frames wait for pause and inserted frame
  assign tx_start_ok = (pause_q == 16'h0000) && !pend_q &&
                       st_q == mpfc_pkg::TX_IDLE && !ptx_valid;

  // ===================================================
  // checks
  load_value_a: assert property (@(posedge mclk) disable iff (rst)
    load |=> pause_q == $past(qn_now))
    else $error("pause counter not loaded with quantum");
  half_dup_a: assert property (@(posedge mclk) disable iff (rst)
    (!full_dup && pause_q == 16'h0000) |=> pause_q == 16'h0000)
    else $error("pause counter loaded in half duplex");
  nz_status_a: assert property (@(posedge mclk) disable iff (rst)
    (rx_good && rx_nonzero) |=> stat_q[`MPFC_INT_PAUSE_NZ])
    else $error("nonzero pause status not set");
  zero_irq_a: assert property (@(posedge mclk) disable iff (rst)
    zero_evt |=> pause_q == 16'h0000 && stat_q[`MPFC_INT_PAUSE_Z])
    else $error("countdown to zero not flagged");
  hold_tx_a: assert property (@(posedge mclk) disable iff (rst)
    pause_q != 16'h0000 |-> !tx_start_ok)
    else $error("new frame allowed while paused");
  no_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    (pause_q == 16'h0000 && !load) |=> pause_q == 16'h0000)
    else $error("pause counter wrapped below zero");
  pfc_drop_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_q[`MPFC_CFG_PFC_NEG] |-> !rx_good)
    else $error("pause accepted after pfc negotiation");
  stat_inc_a: assert property (@(posedge mclk) disable iff (rst)
    rx_good |=> rx_cnt_q == $past(rx_cnt_q) + 32'h0000_0001)
    else $error("receive statistic not incremented");
  busy_stall_a: assert property (@(posedge mclk) disable iff (rst)
    (mac_tx_busy && !load) |=> pause_q == $past(pause_q))
    else $error("counter moved during frame in progress");
endmodule // mpfc_top

/* testbench/mpfc_station.sv */
// far-end station model: sends frames in, captures pause frames out
`timescale 1ns/100ps
module mpfc_station
(
  // clock
  input  wire logic       mclk,
  // frame stream into the block
  output logic            rx_valid,
  output logic            rx_sof,
  output logic            rx_eof,
  output logic      [7:0] rx_data,
  output logic            rx_err,
  // pause frame stream out of the block
  input  wire logic       ptx_valid,
  input  wire logic       ptx_sof,
  input  wire logic       ptx_eof,
  input  wire logic [7:0] ptx_data
);
  logic [7:0] cap [64];
  int         cap_n = 0;
  int         nframes = 0;
  int         ph = 0;
  initial
  begin
    rx_valid = 1'b0;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
    rx_data  = 8'h00;
    rx_err   = 1'b0;
  end
  // ==================================================
  // sending
  task automatic send(input logic [47:0] da, input logic [15:0] ty,
                      input logic [15:0] op, input logic [15:0] q,
                      input logic err);
    logic [7:0] b [60];
    b = '{default: 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      b[i]     = da[47-8*i -: 8];
      b[i + 6] = 8'h60 + 8'(i);
    end
    {b[12], b[13], b[14], b[15], b[16], b[17]} = {ty, op, q};
    for (int i = 0; i < 60; i++)
    begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_eof   <= (i == 59);
      rx_data  <= b[i];
      rx_err   <= err;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_eof   <= 1'b0;
    rx_err   <= 1'b0;
    // idle data must not look like a held last byte
    rx_data  <= ~b[59];
  endtask
  // ==================================================
  // capture: a byte stands one link tick (16 mclk), sample mid-byte
  always @(posedge mclk)
  begin
    if (ph == 0 && ptx_valid && ptx_sof)
    begin
      ph = 1;
      cap_n = 0;
      nframes++;
    end
    else if (ph != 0)
      ph++;
    if (ph % 16 == 8 && cap_n < 64)
    begin
      cap[cap_n] = ptx_data;
      cap_n++;
      if (ptx_eof || !ptx_valid)
        ph = 0;
    end
  end
endmodule // mpfc_station

/* testbench/mpfc_top_tb.sv */
// self-checking bench of the pause flow-control block
`timescale 1ns/100ps
`include "mpfc_cfg.svh"
module mpfc_top_tb;
  localparam int          BPT = 8;
  localparam int          SLOT = `MPFC_SLOT_BITS / BPT * 16;
  localparam logic [31:0] FD = 32'h1 << `MPFC_CFG_FULL_DUP;
  localparam logic [31:0] RT = 32'h1 << `MPFC_CFG_RETRY;
  localparam logic [31:0] PE = 32'h1 << `MPFC_CFG_PAUSE_EN;
  localparam logic [31:0] PF = 32'h1 << `MPFC_CFG_PFC_NEG;
  localparam logic [31:0] TXE = 32'h1 << `MPFC_CTRL_TX_EN;
  localparam logic [31:0] NZ = 32'h1 << `MPFC_INT_PAUSE_NZ;
  localparam logic [31:0] ZQ = 32'h1 << `MPFC_INT_PAUSE_Z;
  localparam logic [47:0] SA1 = 48'h0211_2233_4455;
  localparam logic [47:0] DAC = `MPFC_DA_CTRL;
  localparam logic [15:0] TY = `MPFC_TYPE_CTRL;
  localparam logic [15:0] OP = `MPFC_OPC_PAUSE;
  localparam logic [7:0]  OCT = `MPFC_OFS_NET_CTRL;
  localparam logic [7:0]  OCF = `MPFC_OFS_NET_CFG;
  localparam logic [7:0]  OST = `MPFC_OFS_INT_STAT;
  localparam logic [7:0]  OPT = `MPFC_OFS_PAUSE_TIME;
  logic        mclk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        mac_transmit_clock;
  logic        rx_valid;
  logic        rx_sof;
  logic        rx_eof;
  logic [7:0]  rx_data;
  logic        rx_err;
  logic        mac_tx_busy;
  logic        tx_start_ok;
  logic        ptx_valid;
  logic        ptx_sof;
  logic        ptx_eof;
  logic [7:0]  ptx_data;
  int          err_count = 0;
  int          samples_checked = 0;
  mpfc_top #(.BITS_PER_TICK(BPT)) uut
  (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .mac_transmit_clock(mac_transmit_clock), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .rx_err(rx_err),
    .mac_tx_busy(mac_tx_busy), .tx_start_ok(tx_start_ok),
    .ptx_valid(ptx_valid), .ptx_sof(ptx_sof), .ptx_eof(ptx_eof),
    .ptx_data(ptx_data)
  );
  mpfc_station station
  (
    .mclk(mclk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data), .rx_err(rx_err), .ptx_valid(ptx_valid),
    .ptx_sof(ptx_sof), .ptx_eof(ptx_eof), .ptx_data(ptx_data)
  );
  // ==================================================
  // clocks; link clock phase unrelated to mclk
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    mac_transmit_clock = 1'b0;
    #7;
    forever #32 mac_transmit_clock = ~mac_transmit_clock;
  end
  // ==================================================
  // helpers
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string w);
    logic [31:0] d;
    rd(a, d);
    chk(w, e, d);
  endtask
  task automatic ticks(input int n);
    repeat (n * 16) @(posedge mclk);
    #1;
  endtask
  task automatic busy(input logic b);
    @(posedge mclk);
    mac_tx_busy <= b;
  endtask
  function automatic logic [31:0] fcs(input logic [7:0] b [64]);
    logic [31:0] c;
    c = `MPFC_CRC_INIT;
    for (int i = 0; i < 60; i++)
    begin
      c = c ^ {24'h0, b[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ `MPFC_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset;
    chk("start ok", 32'h1, {31'h0, tx_start_ok});
    chk("irq", 32'h0, {31'h0, irq});
    rc(`MPFC_OFS_TX_QUANT, 32'h0000_ffff, "quantum reset");
    wr(OPT, 32'h0000_0055);
    rc(OPT, 32'h0, "pause time read only");
    rc(8'h24, 32'h0, "unmapped");
  endtask
  task automatic t_count;
    wr(OCF, FD | PE | RT);
    station.send(SA1, TY, OP, 16'h0003, 1'b0);
    ticks(0);
    chk("start ok", 32'h0, {31'h0, tx_start_ok});
    chk("irq", 32'h1, {31'h0, irq});
    rc(OST, NZ, "status nonzero");
    ticks(6);
    chk("start ok", 32'h1, {31'h0, tx_start_ok});
    rc(OPT, 32'h0, "pause time");
    rc(OST, ZQ, "status zero");
  endtask
  task automatic t_refuse;
    // opcode, type, error, address, negotiated pfc
    for (int k = 0; k < 5; k++)
    begin
      wr(OCF, FD | PE | RT | (k == 4 ? PF : 32'h0));
      station.send(k == 3 ? 48'h0180_c200_0002 : DAC,
                   k == 1 ? 16'h8809 : TY, k == 0 ? 16'h0002 : OP,
                   16'h0008, k == 2);
      rc(OPT, 32'h0, "refused count");
      rc(OST, 32'h0, "refused status");
    end
  endtask
  task automatic t_half;
    wr(OCF, PE);
    station.send(SA1, TY, OP, 16'h0009, 1'b0);
    ticks(0);
    chk("irq", 32'h1, {31'h0, irq});
    chk("start ok", 32'h1, {31'h0, tx_start_ok});
    rc(OPT, 32'h0, "half duplex count");
    rc(OST, NZ, "half duplex status");
    wr(`MPFC_OFS_INT_MASK, ZQ);
    station.send(SA1, TY, OP, 16'h0009, 1'b0);
    ticks(0);
    chk("masked irq", 32'h0, {31'h0, irq});
    rc(OST, NZ, "masked status");
    wr(`MPFC_OFS_INT_MASK, NZ | ZQ);
    rc(`MPFC_OFS_RX_STAT, 32'h3, "pause statistic");
  endtask
  task automatic t_hold;
    wr(OCF, FD | PE | RT);
    busy(1'b1);
    station.send(DAC, TY, OP, 16'h0007, 1'b0);
    ticks(4);
    rc(OPT, 32'h7, "held count");
    chk("start ok", 32'h0, {31'h0, tx_start_ok});
    station.send(DAC, TY, OP, 16'h0005, 1'b0);
    rc(OPT, 32'h5, "reloaded count");
    station.send(DAC, TY, OP, 16'h0000, 1'b0);
    rc(OPT, 32'h0, "zero quantum");
    rc(OST, NZ | ZQ, "both status");
    chk("start ok", 32'h1, {31'h0, tx_start_ok});
    busy(1'b0);
  endtask
  task automatic wait_pt(input logic [31:0] v, output int n);
    logic [31:0] d;
    n = 0;
    d = 32'hffff_ffff;
    while (d !== v && n < 3000)
    begin
      rd(OPT, d);
      n += 2;
    end
  endtask
  task automatic t_slot;
    int          n;
    logic [31:0] d;
    wr(OCF, FD | PE);
    station.send(DAC, TY, OP, 16'h0002, 1'b0);
    wait_pt(32'h1, n);
    wait_pt(32'h0, n);
    chk("slot span", 32'h1, {31'h0, n >= SLOT - 8 && n <= SLOT + 8});
    ticks(3);
    rc(OPT, 32'h0, "no wrap");
    rd(OST, d);
  endtask
  task automatic t_tx;
    logic [7:0] e [64];
    int         f;
    f = station.nframes;
    wr(`MPFC_OFS_TX_QUANT, 32'h0000_1234);
    wr(OCF, PE);
    wr(OCT, TXE | (32'h1 << `MPFC_CTRL_PAUSE_B));
    wr(OCF, FD);
    // disable first, so the next request meets a stopped transmitter
    wr(OCT, 32'h0);
    wr(OCT, 32'h1 << `MPFC_CTRL_PAUSE_A);
    busy(1'b1);
    wr(OCT, TXE);
    wr(OCT, TXE | (32'h1 << `MPFC_CTRL_PAUSE_A));
    ticks(4);
    chk("frames held", 32'(f), 32'(station.nframes));
    chk("start ok", 32'h0, {31'h0, tx_start_ok});
    busy(1'b0);
    ticks(4);
    chk("frames sent", 32'(f + 1), 32'(station.nframes));
    ticks(66);
    e = '{default: 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      e[i]     = DAC[47-8*i -: 8];
      e[i + 6] = SA1[47-8*i -: 8];
    end
    {e[12], e[13], e[14], e[15], e[16], e[17]} = {TY, OP, 16'h1234};
    {e[63], e[62], e[61], e[60]} = fcs(e);
    chk("frame length", 32'h40, 32'(station.cap_n));
    for (int i = 0; i < 64; i++)
      chk("frame byte", {24'h0, e[i]}, {24'h0, station.cap[i]});
  endtask
  // ==================================================
  // main sequence and watchdog
  initial
  begin
    rst         = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    mac_tx_busy = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_reset();
    wr(`MPFC_OFS_SA1_BOT, 32'h3322_1102);
    wr(`MPFC_OFS_SA1_TOP, 32'h0000_5544);
    wr(`MPFC_OFS_INT_MASK, NZ | ZQ);
    wr(OCT, TXE);
    t_count();
    t_refuse();
    t_half();
    t_hold();
    t_slot();
    t_tx();
    print_verdict();
  end
  initial
  begin
    #200000;
    err_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // mpfc_top_tb
